// ---- logic/css_pkg.sv ----
// Purpose: shared constants for the controller status output block
// Assumes: 20 MHz core clock, plain register port with 3-bit word index
// Notes: offsets are word indexes on the register port
package css_pkg;

    // clock and timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned RESET_PULSE_MS = 100;
    localparam int unsigned RESET_PULSE_CYC = (CLK_HZ / 1000) * RESET_PULSE_MS;

    // register port
    localparam int ADDR_W = 3;
    localparam int DATA_W = 32;
    localparam logic [2:0] REG_MODE = 3'h0;
    localparam logic [2:0] REG_SELECT = 3'h1;
    localparam logic [2:0] REG_INHIBIT = 3'h2;
    localparam logic [2:0] REG_CTRL = 3'h3;
    localparam logic [2:0] REG_STATUS = 3'h4;
    localparam logic [2:0] REG_SWITCH = 3'h5;

    // mode register fields
    localparam int MODE_OP_LSB = 0;
    localparam int MODE_KEYED_BIT = 2;
    localparam int MODE_SBLOCK_BIT = 3;
    localparam int MODE_CONV_BIT = 4;
    localparam int MODE_LATHE_BIT = 5;
    localparam logic [5:0] MODE_RESET = 6'h00;

    // ctrl register fields (write-only strobes)
    localparam int CTRL_ALARM_CLR_BIT = 0;
    localparam int CTRL_RESET_KEY_BIT = 1;

    // inhibit mask layout: feed positions start here
    localparam int INH_FEED_LSB = 8;
    localparam logic [31:0] INHIBIT_RESET = 32'h0000_0000;

    // switch word layout
    localparam int SW_JOG_LSB = 0;
    localparam int SW_FEED_LSB = 4;
    localparam int SW_FIELD_W = 4;
    localparam logic [3:0] FEED_MAX_CODE = 4'hE;
    localparam logic [3:0] FEED_ZERO_CODE = 4'h0;
    localparam logic [7:0] SELECT_RESET = 8'h00;

    // motion flag bit order
    localparam int MOT_RAPID = 0;
    localparam int MOT_TAP = 1;
    localparam int MOT_SCREW_CUT_FLAG = 2;
    localparam int MOT_PROBE = 3;
    localparam int MOT_HOME = 4;
    localparam int MOT_N = 5;

    // partner input order in the synchroniser
    localparam int PIN_RESET_REQ = 0;
    localparam int PIN_CYC_START = 1;
    localparam int PIN_STOP_N = 2;
    localparam int PIN_N = 3;
    localparam logic [2:0] PIN_IDLE = 3'h4;

    typedef enum logic [1:0] {
        CSS_OP_NONE = 2'b00,
        CSS_OP_JOG = 2'b01,
        CSS_OP_AUTO = 2'b10,
        CSS_OP_OTHER = 2'b11
    } css_op_t;

endpackage : css_pkg

// ---- logic/css_status_out.sv ----
// Purpose: general status outputs presented by the motion controller to the PLC
// Assumes: core inputs are on core_clk_in; PLC pins are asynchronous
// Notes: all outputs come from flip-flops; register reads answer one cycle later
//
// How it works
// R01: reset key or request gives 100 ms pulse
// R02: loop-open flag follows axis loop error
// R03: alarm low on alarm, high after clear
// R04: emergency output low while alarm low
// R05: jog flag high only in jog mode
// R06: auto flag high in automatic mode
// R07: keyed-entry flag follows keyed entry selection
// R08: single-block flag follows single-block selection
// R09: work-mode bit 0 basic, 1 conversational
// R10: cycle active while block executes or axis moves
// R11: after start, active until end or stop
// R12: single block drops active at block end
// R13: jog drops at position; jog key holds
// R14: one flag per executing motion type
// R15: rigid tapping flag, mill variant only
// R16: retrace-done when all blocks retraced
// R17: surface speed flag, lathe variant only
// R18: selected word plus eight applied bits
// R19: applied equals selected unless position inhibited
// R20: inhibited feed takes nearest lower, else 0%
// R21: low nibble encodes jog switch codes
// R22: high nibble encodes feed override codes
// R23: outputs clocked together; flags reset low, alarm high
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module css_status_out #(
    parameter int unsigned RESET_PULSE_CYCLES = css_pkg::RESET_PULSE_CYC
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,

    // register port
    input wire logic [css_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [css_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [css_pkg::DATA_W-1:0] reg_rdata_out,

    // controller core events (same clock)
    input wire logic reset_key_in,
    input wire logic stop_key_in,
    input wire logic loop_error_in,
    input wire logic alarm_detect_in,
    input wire logic block_exec_in,
    input wire logic axis_moving_in,
    input wire logic program_end_in,
    input wire logic block_done_in,
    input wire logic position_reached_in,
    input wire logic jog_key_in,
    input wire logic [css_pkg::MOT_N-1:0] motion_exec_in,
    input wire logic rigid_tap_exec_in,
    input wire logic retrace_active_in,
    input wire logic retrace_all_done_in,
    input wire logic css_selected_in,

    // partner pins (asynchronous)
    input wire logic reset_request_input,
    input wire logic cycle_start_request,
    input wire logic stop_request_n_in,

    // status outputs
    output logic reset_indication_pulse,
    output logic loop_open_flag,
    output logic alarm_n_out,
    output logic emergency_n_out,
    output logic jog_mode_flag,
    output logic auto_run_flag,
    output logic keyed_entry_flag,
    output logic single_block_flag,
    output logic work_mode_select,
    output logic cycle_active,
    output logic rapid_move_flag,
    output logic tap_cycle_flag,
    output logic screw_cut_flag,
    output logic probe_move_flag,
    output logic home_search_flag,
    output logic locked_tap_flag,
    output logic backtrack_done_flag,
    output logic const_surface_speed_flag,
    output logic [7:0] switch_position_word,
    output logic applied_switch_bit0,
    output logic applied_switch_bit1,
    output logic applied_switch_bit2,
    output logic applied_switch_bit3,
    output logic applied_switch_bit4,
    output logic applied_switch_bit5,
    output logic applied_switch_bit6,
    output logic applied_switch_bit7
);

    ////////////////////////////////////////////////////////////////////////
    // state

    localparam int CNT_W = $clog2(RESET_PULSE_CYCLES + 1);
    localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(RESET_PULSE_CYCLES);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    typedef struct packed {
        // three-stage pin synchroniser plus filtered level
        logic [css_pkg::PIN_N-1:0] pin_s1;
        logic [css_pkg::PIN_N-1:0] pin_s2;
        logic [css_pkg::PIN_N-1:0] pin_s3;
        logic [css_pkg::PIN_N-1:0] pin_lvl;

        // software registers
        logic [5:0] mode;
        logic [7:0] selected;
        logic [31:0] inhibit;

        // internal state
        logic [CNT_W-1:0] pulse_cnt;
        logic msg_pending;
        logic cyc_run;

        // outputs
        logic reset_pulse;
        logic loop_open;
        logic alarm_n;
        logic jog_f;
        logic auto_f;
        logic keyed_f;
        logic sblock_f;
        logic conv_f;
        logic cyc_f;
        logic [css_pkg::MOT_N-1:0] mot_f;
        logic rigid_f;
        logic retr_f;
        logic css_f;
        logic [7:0] sel_word;
        logic [7:0] applied;
        logic [css_pkg::DATA_W-1:0] rdata;
    } css_state_t;

    css_state_t st_q;
    css_state_t st_d;

    ////////////////////////////////////////////////////////////////////////
    // feed override resolution

    // walks down from the selected code to the first allowed position
    function automatic logic [3:0] css_feed_apply(
        input logic [3:0] sel,
        input logic [31:0] inh
    );
        logic [3:0] res;
        logic found;
        res = css_pkg::FEED_ZERO_CODE;
        found = 1'b0;
        // codes above the top position are passed through untouched
        if (sel > css_pkg::FEED_MAX_CODE) begin
            res = sel;
            found = 1'b1;
        end
        for (int i = 14; i >= 0; i--) begin
            if (!found && (4'(i) <= sel) && !inh[css_pkg::INH_FEED_LSB + i]) begin
                res = 4'(i); // R20
                found = 1'b1;
            end
        end
        return res;
    endfunction : css_feed_apply

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [css_pkg::PIN_N-1:0] lvl_new;
        logic req_rise;
        logic start_rise;
        logic stop_now;

        logic wr_mode;
        logic wr_sel;
        logic wr_inh;
        logic wr_ctrl;
        logic alarm_clr;
        logic sw_reset_key;

        logic [5:0] mode_now;
        css_pkg::css_op_t op;
        logic lathe;
        logic drop;

        logic [3:0] feed_app;
        logic [css_pkg::DATA_W-1:0] rd;

        st_d = st_q;

        // pin synchroniser: a change counts once stage 2 and 3 agree
        st_d.pin_s1 = {stop_request_n_in, cycle_start_request, reset_request_input};
        st_d.pin_s2 = st_q.pin_s1;
        st_d.pin_s3 = st_q.pin_s2;

        lvl_new = st_q.pin_lvl;
        for (int i = 0; i < css_pkg::PIN_N; i++) begin
            if (st_q.pin_s2[i] == st_q.pin_s3[i]) begin
                lvl_new[i] = st_q.pin_s3[i];
            end
        end
        st_d.pin_lvl = lvl_new;
        req_rise = lvl_new[css_pkg::PIN_RESET_REQ] & ~st_q.pin_lvl[css_pkg::PIN_RESET_REQ];
        start_rise = lvl_new[css_pkg::PIN_CYC_START] & ~st_q.pin_lvl[css_pkg::PIN_CYC_START];
        stop_now = stop_key_in | ~lvl_new[css_pkg::PIN_STOP_N];

        // register writes
        wr_mode = reg_write_in && (reg_addr_in == css_pkg::REG_MODE);
        wr_sel = reg_write_in && (reg_addr_in == css_pkg::REG_SELECT);
        wr_inh = reg_write_in && (reg_addr_in == css_pkg::REG_INHIBIT);
        wr_ctrl = reg_write_in && (reg_addr_in == css_pkg::REG_CTRL);
        alarm_clr = wr_ctrl & reg_wdata_in[css_pkg::CTRL_ALARM_CLR_BIT];
        sw_reset_key = wr_ctrl & reg_wdata_in[css_pkg::CTRL_RESET_KEY_BIT];

        if (wr_mode) begin
            st_d.mode = reg_wdata_in[5:0];
        end
        if (wr_sel) begin
            st_d.selected = reg_wdata_in[7:0];
        end
        if (wr_inh) begin
            st_d.inhibit = reg_wdata_in;
        end

        mode_now = st_q.mode;
        op = css_pkg::css_op_t'(mode_now[css_pkg::MODE_OP_LSB +: 2]);
        lathe = mode_now[css_pkg::MODE_LATHE_BIT];

        // reset indication: retriggerable fixed-length pulse
        if (reset_key_in || req_rise || sw_reset_key) begin
            st_d.pulse_cnt = PULSE_LOAD; // R01
        end else if (st_q.pulse_cnt != CNT_ZERO) begin
            st_d.pulse_cnt = st_q.pulse_cnt - CNT_ONE;
        end
        st_d.reset_pulse = (st_d.pulse_cnt != CNT_ZERO); // R01

        st_d.loop_open = loop_error_in; // R02

        // alarm: message stays until software clears it; a new alarm wins
        if (alarm_detect_in) begin
            st_d.msg_pending = 1'b1; // R03
        end else if (alarm_clr) begin
            st_d.msg_pending = 1'b0;
        end
        st_d.alarm_n = ~(st_d.msg_pending | alarm_detect_in); // R03

        // operating mode flags
        st_d.jog_f = (op == css_pkg::CSS_OP_JOG); // R05
        st_d.auto_f = (op == css_pkg::CSS_OP_AUTO); // R06

        st_d.keyed_f = mode_now[css_pkg::MODE_KEYED_BIT]; // R07
        st_d.sblock_f = mode_now[css_pkg::MODE_SBLOCK_BIT]; // R08
        st_d.conv_f = mode_now[css_pkg::MODE_CONV_BIT]; // R09

        // cycle run latch
        drop = program_end_in | stop_now; // R11

        if (mode_now[css_pkg::MODE_SBLOCK_BIT] && block_done_in) begin
            drop = 1'b1; // R12
        end
        if ((op == css_pkg::CSS_OP_JOG) && position_reached_in) begin
            drop = 1'b1; // R13
        end
        if (start_rise && !stop_now) begin
            st_d.cyc_run = 1'b1; // R11
        end else if (drop) begin
            st_d.cyc_run = 1'b0;
        end
        // a fresh start outranks an end, block-done or position drop in the same cycle; a stop outranks the start
        st_d.cyc_f = st_d.cyc_run | block_exec_in | axis_moving_in // R10
            | ((op == css_pkg::CSS_OP_JOG) & jog_key_in); // R13

        // motion flags
        st_d.mot_f = motion_exec_in; // R14
        st_d.rigid_f = rigid_tap_exec_in & ~lathe; // R15
        st_d.retr_f = retrace_active_in & retrace_all_done_in; // R16
        st_d.css_f = css_selected_in & lathe; // R17

        // switch words
        feed_app = css_feed_apply(st_q.selected[css_pkg::SW_FEED_LSB +: css_pkg::SW_FIELD_W], st_q.inhibit);
        st_d.sel_word = st_q.selected; // R18
        st_d.applied = {feed_app, st_q.selected[css_pkg::SW_JOG_LSB +: css_pkg::SW_FIELD_W]}; // R19

        // read data valid only in the cycle after the strobe
        rd = '0;
        if (reg_read_in) begin
            unique case (reg_addr_in)
                css_pkg::REG_MODE: begin
                    rd[5:0] = st_q.mode;
                end
                css_pkg::REG_SELECT: begin
                    rd[7:0] = st_q.selected;
                end
                css_pkg::REG_INHIBIT: begin
                    rd = st_q.inhibit;
                end
                css_pkg::REG_STATUS: begin
                    rd[17:0] = {st_q.css_f, st_q.retr_f, st_q.rigid_f, st_q.mot_f, st_q.cyc_f, st_q.conv_f,
                        st_q.sblock_f, st_q.keyed_f, st_q.auto_f, st_q.jog_f, st_q.msg_pending, st_q.alarm_n,
                        st_q.loop_open, st_q.reset_pulse};
                end
                css_pkg::REG_SWITCH: begin
                    rd[15:0] = {st_q.applied, st_q.sel_word};
                end
                default: begin
                    rd = '0;
                end
            endcase
        end
        st_d.rdata = rd;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            st_q <= '0; // R23
            st_q.pin_lvl <= css_pkg::PIN_IDLE;
            st_q.pin_s1 <= css_pkg::PIN_IDLE;
            st_q.pin_s2 <= css_pkg::PIN_IDLE;
            st_q.pin_s3 <= css_pkg::PIN_IDLE;

            st_q.mode <= css_pkg::MODE_RESET;
            st_q.inhibit <= css_pkg::INHIBIT_RESET;
            st_q.selected <= css_pkg::SELECT_RESET;
            st_q.alarm_n <= 1'b1; // R23
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata_out = st_q.rdata;

    assign reset_indication_pulse = st_q.reset_pulse;
    assign loop_open_flag = st_q.loop_open;
    assign alarm_n_out = st_q.alarm_n;
    assign emergency_n_out = st_q.alarm_n; // R04

    assign jog_mode_flag = st_q.jog_f;
    assign auto_run_flag = st_q.auto_f;
    assign keyed_entry_flag = st_q.keyed_f;
    assign single_block_flag = st_q.sblock_f;
    assign work_mode_select = st_q.conv_f;
    assign cycle_active = st_q.cyc_f;

    assign rapid_move_flag = st_q.mot_f[css_pkg::MOT_RAPID];
    assign tap_cycle_flag = st_q.mot_f[css_pkg::MOT_TAP];
    assign screw_cut_flag = st_q.mot_f[css_pkg::MOT_SCREW_CUT_FLAG];
    assign probe_move_flag = st_q.mot_f[css_pkg::MOT_PROBE];
    assign home_search_flag = st_q.mot_f[css_pkg::MOT_HOME];

    assign locked_tap_flag = st_q.rigid_f;
    assign backtrack_done_flag = st_q.retr_f;
    assign const_surface_speed_flag = st_q.css_f;

    assign switch_position_word = st_q.sel_word; // R21 R22
    assign applied_switch_bit0 = st_q.applied[0];
    assign applied_switch_bit1 = st_q.applied[1];
    assign applied_switch_bit2 = st_q.applied[2];
    assign applied_switch_bit3 = st_q.applied[3];
    assign applied_switch_bit4 = st_q.applied[4];
    assign applied_switch_bit5 = st_q.applied[5];
    assign applied_switch_bit6 = st_q.applied[6];
    assign applied_switch_bit7 = st_q.applied[7];

endmodule : css_status_out

`default_nettype wire

// ---- verif/css_status_props.sv ----
// Purpose: concurrent checks on the status outputs
// Assumes: one clock, synchronous active-low reset
// Notes: bound into css_status_out below
`timescale 1ns/1ns
`default_nettype none
module css_status_props #(
    parameter int unsigned RESET_PULSE_CYCLES = 20
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // causes
    input wire logic [css_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [css_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reset_key_in,
    input wire logic loop_error_in,
    input wire logic alarm_detect_in,
    input wire logic block_exec_in,
    input wire logic [css_pkg::MOT_N-1:0] motion_exec_in,
    // status
    input wire logic reset_indication_pulse,
    input wire logic loop_open_flag,
    input wire logic alarm_n_out,
    input wire logic emergency_n_out,
    input wire logic jog_mode_flag,
    input wire logic work_mode_select,
    input wire logic cycle_active,
    input wire logic rapid_move_flag,
    input wire logic tap_cycle_flag,
    input wire logic screw_cut_flag,
    input wire logic probe_move_flag,
    input wire logic home_search_flag
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    wire logic mode_wr = reg_write_in && reg_addr_in == css_pkg::REG_MODE;
    logic [31:0] since_key_q;
    // saturates so an idle count never looks like a fresh key
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) since_key_q <= RESET_PULSE_CYCLES;
        else if (reset_key_in) since_key_q <= '0;
        else if (since_key_q < RESET_PULSE_CYCLES) since_key_q <= since_key_q + 32'h1;
    end
    ////////////////////////////////////////////////////////////////////////
    a_pulse_held: assert property (since_key_q < RESET_PULSE_CYCLES |-> reset_indication_pulse)
        else $error("reset pulse dropped early");
    a_loop_open_tracks: assert property (1'b1 |=> loop_open_flag == $past(loop_error_in))
        else $error("loop open flag wrong");
    a_alarm_on_detect: assert property (alarm_detect_in |=> !alarm_n_out)
        else $error("alarm output not low");
    a_emerg_with_alarm: assert property (!alarm_n_out |-> !emergency_n_out)
        else $error("emergency output not low");
    a_jog_mode_flag: assert property (mode_wr |-> ##3 jog_mode_flag == ($past(reg_wdata_in[1:0], 3) == 2'h1))
        else $error("jog flag wrong");
    a_work_mode_bit: assert property (mode_wr |-> ##3 work_mode_select == $past(reg_wdata_in[4], 3))
        else $error("work mode bit wrong");
    a_cycle_on_exec: assert property (block_exec_in |=> cycle_active)
        else $error("cycle flag low during block");
    a_motion_flags: assert property (1'b1 |=> {home_search_flag, probe_move_flag, screw_cut_flag,
        tap_cycle_flag, rapid_move_flag} == $past(motion_exec_in)) else $error("motion flags wrong");
    c_pulse_end: cover property ($fell(reset_indication_pulse));
    c_alarm: cover property ($fell(alarm_n_out));
    c_cycle_end: cover property ($fell(cycle_active));
endmodule : css_status_props
bind css_status_out css_status_props #(.RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)) u_props (.*);
`default_nettype wire

// ---- verif/css_plc_model.sv ----
// Purpose: plc model driving the request pins
// Assumes: bench pulses each command for one clock
// Notes: pins move 7 ns after the edge
`timescale 1ns/1ns
`default_nettype none
module css_plc_model #(
    parameter int HOLD_CYC = 4
) (
    // clock
    input wire logic core_clk_in,
    // bench commands
    input wire logic reset_cmd_in,
    input wire logic start_cmd_in,
    input wire logic stop_cmd_in,
    // pins toward the controller
    output wire logic reset_request_input,
    output wire logic cycle_start_request,
    output wire logic stop_request_n_in
);
    int rst_left = 0, go_left = 0, stop_left = 0;
    // held past the two-clock filter so no request is lost
    always @(posedge core_clk_in) begin
        rst_left <= reset_cmd_in ? HOLD_CYC : rst_left - (rst_left > 0);
        go_left <= start_cmd_in ? HOLD_CYC : go_left - (go_left > 0);
        stop_left <= stop_cmd_in ? HOLD_CYC : stop_left - (stop_left > 0);
    end
    assign #7 reset_request_input = rst_left > 0;
    assign #7 cycle_start_request = go_left > 0;
    assign #7 stop_request_n_in = !(stop_left > 0);
endmodule : css_plc_model
`default_nettype wire

// ---- verif/testbench.sv ----
// Purpose: self-checking bench for the status outputs
// Assumes: short reset pulse, plc model on the pins
// Notes: switch expectations from a bench model
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int unsigned PULSE = 20;
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [css_pkg::ADDR_W-1:0] reg_addr_in = '0;
    logic [31:0] reg_wdata_in = '0, reg_rdata_out, m, mask;
    logic reg_write_in = 0, reg_read_in = 0, reset_key_in = 0, stop_key_in = 0, loop_error_in = 0;
    logic alarm_detect_in = 0, block_exec_in = 0, axis_moving_in = 0, program_end_in = 0, block_done_in = 0;
    logic position_reached_in = 0, jog_key_in = 0, rigid_tap_exec_in = 0, retrace_active_in = 0;
    logic retrace_all_done_in = 0, css_selected_in = 0, reset_cmd_in = 0, start_cmd_in = 0, stop_cmd_in = 0;
    logic [4:0] motion_exec_in = '0;
    wire reset_request_input, cycle_start_request, stop_request_n_in;
    logic reset_indication_pulse, loop_open_flag, alarm_n_out, emergency_n_out, jog_mode_flag, auto_run_flag;
    logic keyed_entry_flag, single_block_flag, work_mode_select, cycle_active, rapid_move_flag, tap_cycle_flag;
    logic screw_cut_flag, probe_move_flag, home_search_flag, locked_tap_flag, backtrack_done_flag;
    logic const_surface_speed_flag, applied_switch_bit0, applied_switch_bit1, applied_switch_bit2;
    logic applied_switch_bit3, applied_switch_bit4, applied_switch_bit5, applied_switch_bit6, applied_switch_bit7;
    logic [7:0] switch_position_word, s;
    wire logic [7:0] applied = {applied_switch_bit7, applied_switch_bit6, applied_switch_bit5, applied_switch_bit4,
        applied_switch_bit3, applied_switch_bit2, applied_switch_bit1, applied_switch_bit0};
    wire logic [4:0] mot = {home_search_flag, probe_move_flag, screw_cut_flag, tap_cycle_flag, rapid_move_flag};
    int fail_count = 0, tests_run = 0, cycles = 0, i, k, n;
    css_status_out #(.RESET_PULSE_CYCLES(PULSE)) dut (.*);
    css_plc_model u_plc (.*);
    always #25 core_clk_in = ~core_clk_in;
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        if (fail_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task automatic look(input int c);
        repeat (c) @(posedge core_clk_in);
        @(negedge core_clk_in);
    endtask : look
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        reg_write_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge core_clk_in);
        reg_write_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [31:0] exp);
        @(posedge core_clk_in);
        reg_read_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge core_clk_in);
        reg_read_in <= 1'b0;
        @(negedge core_clk_in);
        chk("read data", exp, reg_rdata_out);
    endtask : rd
    // bench model of the feed fallback
    function automatic logic [7:0] applied_model(input logic [7:0] sel, input logic [31:0] msk);
        int f;
        f = sel[7:4];
        while (f > 0 && msk[8 + f]) f--;
        return {f[3:0], sel[3:0]};
    endfunction : applied_model
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h2D2235CA));
        repeat (2) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        @(negedge core_clk_in);
        chk("idle flags", 0, {reset_indication_pulse, loop_open_flag, jog_mode_flag, auto_run_flag, mot,
            keyed_entry_flag, single_block_flag, work_mode_select, cycle_active, locked_tap_flag,
            backtrack_done_flag, const_surface_speed_flag, switch_position_word, applied});
        chk("idle alarm pair", 2'h3, {alarm_n_out, emergency_n_out});
        wr(3'h6, 32'hFFFFFFFF);
        rd(3'h6, 0);
        rd(css_pkg::REG_CTRL, 0);
        for (i = 0; i < 16; i++) begin
            m = $urandom & 32'h3F;
            m[1:0] = i[1:0];
            wr(css_pkg::REG_MODE, m);
            look(2);
            chk("jog flag", m[1:0] == 2'h1, jog_mode_flag);
            chk("auto flag", m[1:0] == 2'h2, auto_run_flag);
            chk("keyed flag", m[2], keyed_entry_flag);
            chk("single flag", m[3], single_block_flag);
            chk("work mode", m[4], work_mode_select);
            rd(css_pkg::REG_MODE, m);
        end
        for (i = 0; i < 30; i++) begin
            s = {4'(i % 15), 4'(i % 9)};
            mask = (i == 29) ? 32'h007FFF00 : $urandom;
            wr(css_pkg::REG_INHIBIT, mask);
            wr(css_pkg::REG_SELECT, {24'h0, s});
            look(2);
            chk("selected word", s, switch_position_word);
            chk("applied bits", applied_model(s, mask), applied);
            rd(css_pkg::REG_SWITCH, {16'h0, applied_model(s, mask), s});
        end
        for (k = 0; k < 3; k++) begin
            if (k == 1) wr(css_pkg::REG_CTRL, 32'h2);
            else begin
                @(posedge core_clk_in);
                reset_key_in <= (k == 0);
                reset_cmd_in <= (k == 2);
                @(posedge core_clk_in);
                {reset_key_in, reset_cmd_in} <= 2'h0;
            end
            n = 0;
            repeat (PULSE + 12) begin
                @(negedge core_clk_in);
                n += (reset_indication_pulse === 1'b1);
            end
            chk("reset pulse cycles", PULSE, n);
        end
        @(posedge core_clk_in);
        {loop_error_in, alarm_detect_in} <= 2'h3;
        look(1);
        chk("loop open", 1, loop_open_flag);
        wr(css_pkg::REG_CTRL, 32'h1);
        look(2);
        chk("alarm with cause", 2'h0, {alarm_n_out, emergency_n_out});
        {loop_error_in, alarm_detect_in} <= 2'h0;
        look(2);
        chk("alarm msg held", 3'h0, {loop_open_flag, alarm_n_out, emergency_n_out});
        wr(css_pkg::REG_CTRL, 32'h1);
        look(2);
        chk("alarm cleared", 2'h3, {alarm_n_out, emergency_n_out});
        for (i = 0; i < 5; i++) begin
            motion_exec_in <= 5'h1 << i;
            look(1);
            chk("motion flags", 5'h1 << i, mot);
        end
        motion_exec_in <= 5'h0;
        {rigid_tap_exec_in, css_selected_in, retrace_active_in, retrace_all_done_in} <= 4'hF;
        for (k = 0; k < 2; k++) begin
            wr(css_pkg::REG_MODE, k << 5);
            look(2);
            chk("rigid and css", {k == 0, k == 1, 1'b1}, {locked_tap_flag, const_surface_speed_flag,
                backtrack_done_flag});
        end
        retrace_active_in <= 1'b0;
        look(1);
        chk("retrace done", 0, backtrack_done_flag);
        for (k = 0; k < 5; k++) begin
            wr(css_pkg::REG_MODE, k == 3 ? 32'hA : (k == 4 ? 32'h1 : 32'h2));
            start_cmd_in <= 1'b1;
            @(posedge core_clk_in);
            start_cmd_in <= 1'b0;
            look(10);
            chk("cycle after start", 1, cycle_active);
            {stop_key_in, program_end_in, stop_cmd_in, block_done_in, position_reached_in} <= 5'h10 >> k;
            @(posedge core_clk_in);
            {stop_key_in, program_end_in, stop_cmd_in, block_done_in, position_reached_in} <= 5'h0;
            look(8);
            chk("cycle dropped", 0, cycle_active);
        end
        jog_key_in <= 1'b1;
        look(1);
        chk("jog key cycle", 1, cycle_active);
        {jog_key_in, block_exec_in} <= 2'h1;
        look(1);
        chk("block cycle", 1, cycle_active);
        {block_exec_in, axis_moving_in} <= 2'h1;
        look(1);
        chk("axis cycle", 1, cycle_active);
        axis_moving_in <= 1'b0;
        look(1);
        chk("cycle idle", 0, cycle_active);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
